// ### design/byte_ops_pkg.sv
// constants, register map and phase encoding for the byte-op datapath
package byte_ops_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_INSTR     = 8'h04;
  localparam logic [7:0] OFF_WREG      = 8'h08;
  localparam logic [7:0] OFF_BANK      = 8'h0C;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_INDEX     = 8'h14;
  localparam logic [7:0] OFF_FILE_ADDR = 8'h18;
  localparam logic [7:0] OFF_FILE_DATA = 8'h1C;

  // field positions
  localparam int CTRL_EXT_BIT      = 0;
  localparam int STATUS_NEG_BIT    = 0;
  localparam int STATUS_ZERO_BIT   = 1;
  localparam int STATUS_BUSY_BIT   = 2;
  localparam int STATUS_UNK_BIT    = 3;
  localparam int OP_DEST_BIT       = 9;
  localparam int OP_BANKSEL_BIT    = 8;

  // opcode patterns
  localparam logic [5:0] OPC_ROTATE = 6'h10;
  localparam logic [6:0] OPC_FILL   = 7'h34;

  // datapath constants
  localparam logic [7:0] FILL_VALUE     = 8'hFF;
  localparam logic [7:0] INDEXED_LIMIT  = 8'h5F;

  // reset values
  localparam logic [7:0]  RST_WREG   = 8'h00;
  localparam logic [15:0] RST_OPCODE = 16'h0000;

  // timing: every phase lasts one clock period
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PHASE_NS        = 10;
  localparam int PHASE_CYCLES    = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } phase_t;

endpackage

// ### design/byte_ops_core.sv
// apb-driven execution datapath for rotate-right-no-carry and fill-with-ones
// Contract
// - rotate opcode rotates file byte right, bit0 into bit7, updates only N and Z
// - rotate destination bit 0 writes accumulator, bit 1 writes file register back
// - bank-select 0 uses access bank, 1 uses bank pointer register
// - indexed offset when extended set on, bank-select 0 and address at most 5Fh
// - fill opcode writes FFh to file register, flags untouched, same bank selection
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module byte_ops_core #(
  parameter int BANK_W = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  localparam int AW    = BANK_W + 8;
  localparam int DEPTH = 1 << AW;

  if (BANK_W < 1 || BANK_W > 8)
  begin : g_bad_bank_w
    $error("BANK_W must lie between 1 and 8");
  end

  typedef struct packed {
    byte_ops_pkg::phase_t phase;
    logic                 ext_en;
    logic [7:0]           wreg;
    logic [BANK_W-1:0]    bank;
    logic                 neg;
    logic                 zero;
    logic                 unknown;
    logic [15:0]          opcode;
    logic [AW-1:0]        index;
    logic [AW-1:0]        file_addr;
    logic [AW-1:0]        eff_addr;
    logic [7:0]           operand;
    logic [7:0]           result;
    logic                 ack;
    logic                 err;
    logic [31:0]          rdata;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // general_purpose_file storage, no reset: contents are software's business
  logic [7:0] file_mem [DEPTH];

  function automatic logic is_rotate(input logic [15:0] op);
    is_rotate = (op[15:10] == byte_ops_pkg::OPC_ROTATE);
  endfunction

  function automatic logic is_fill(input logic [15:0] op);
    is_fill = (op[15:9] == byte_ops_pkg::OPC_FILL);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= byte_ops_pkg::OFF_FILE_DATA);
  endfunction

  // effective file address from operand, bank-select, bank pointer and index base
  function automatic logic [AW-1:0] eff_address(
    input logic [15:0]       op,
    input logic              ext,
    input logic [BANK_W-1:0] bnk,
    input logic [AW-1:0]     idx
  );
    logic [7:0] f;
    logic       a;
    f = op[7:0];
    a = op[byte_ops_pkg::OP_BANKSEL_BIT];
    if (a)
      eff_address = {bnk, f};
    else if (ext && (f <= byte_ops_pkg::INDEXED_LIMIT))
      eff_address = idx + AW'(f);
    else if (f <= byte_ops_pkg::INDEXED_LIMIT)
      eff_address = {{BANK_W{1'b0}}, f};
    else
      eff_address = {{BANK_W{1'b1}}, f};
  endfunction

  logic          wr_hit;
  logic          rd_load;
  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0]    mem_wdata;

  // a write lands only at the completing access edge, always while idle
  assign wr_hit  = psel && penable && st.ack && pwrite;
  // read data is prepared only while idle, so nothing can change it before the ack edge
  assign rd_load = psel && !(penable && st.ack) && (st.phase == byte_ops_pkg::PH_IDLE);
  assign pready  = st.ack;
  assign prdata  = st.rdata;
  assign pslverr = st.ack && st.err;

  always_comb
  begin
    next_st   = st;
    mem_we    = 1'b0;
    mem_waddr = st.file_addr;
    mem_wdata = pwdata[7:0];
    next_st.ack = rd_load;
    next_st.err = rd_load && !is_mapped(paddr);
    if (rd_load)
    begin
      case (paddr)
        byte_ops_pkg::OFF_CTRL:      next_st.rdata = 32'(st.ext_en);
        byte_ops_pkg::OFF_INSTR:     next_st.rdata = 32'(st.opcode);
        byte_ops_pkg::OFF_WREG:      next_st.rdata = 32'(st.wreg);
        byte_ops_pkg::OFF_BANK:      next_st.rdata = 32'(st.bank);
        byte_ops_pkg::OFF_STATUS:    next_st.rdata = 32'({st.unknown, 1'b0, st.zero, st.neg});
        byte_ops_pkg::OFF_INDEX:     next_st.rdata = 32'(st.index);
        byte_ops_pkg::OFF_FILE_ADDR: next_st.rdata = 32'(st.file_addr);
        byte_ops_pkg::OFF_FILE_DATA: next_st.rdata = 32'(file_mem[st.file_addr]);
        default:                     next_st.rdata = 32'h00000000;
      endcase
    end
    if (wr_hit)
    begin
      case (paddr)
        byte_ops_pkg::OFF_CTRL:      next_st.ext_en = pwdata[byte_ops_pkg::CTRL_EXT_BIT];
        byte_ops_pkg::OFF_WREG:      next_st.wreg = pwdata[7:0];
        byte_ops_pkg::OFF_BANK:      next_st.bank = pwdata[BANK_W-1:0];
        byte_ops_pkg::OFF_STATUS:
        begin
          next_st.neg     = pwdata[byte_ops_pkg::STATUS_NEG_BIT];
          next_st.zero    = pwdata[byte_ops_pkg::STATUS_ZERO_BIT];
          next_st.unknown = pwdata[byte_ops_pkg::STATUS_UNK_BIT];
        end
        byte_ops_pkg::OFF_INDEX:     next_st.index = pwdata[AW-1:0];
        byte_ops_pkg::OFF_FILE_ADDR: next_st.file_addr = pwdata[AW-1:0];
        byte_ops_pkg::OFF_FILE_DATA: mem_we = 1'b1;
        byte_ops_pkg::OFF_INSTR:
        begin
          next_st.opcode  = pwdata[15:0];
          next_st.unknown = !(is_rotate(pwdata[15:0]) || is_fill(pwdata[15:0]));
          if (is_rotate(pwdata[15:0]) || is_fill(pwdata[15:0]))
            next_st.phase = byte_ops_pkg::PH_Q1;
        end
        default: ;
      endcase
    end
    case (st.phase)
      byte_ops_pkg::PH_IDLE: ;
      byte_ops_pkg::PH_Q1:
      begin
        next_st.eff_addr = eff_address(st.opcode, st.ext_en, st.bank, st.index);
        next_st.phase    = byte_ops_pkg::PH_Q2;
      end
      byte_ops_pkg::PH_Q2:
      begin
        next_st.operand = file_mem[st.eff_addr];
        next_st.phase   = byte_ops_pkg::PH_Q3;
      end
      byte_ops_pkg::PH_Q3:
      begin
        if (is_rotate(st.opcode))
          next_st.result = {st.operand[0], st.operand[7:1]};
        else
          next_st.result = byte_ops_pkg::FILL_VALUE;
        next_st.phase = byte_ops_pkg::PH_Q4;
      end
      byte_ops_pkg::PH_Q4:
      begin
        next_st.phase = byte_ops_pkg::PH_IDLE;
        mem_waddr     = st.eff_addr;
        mem_wdata     = st.result;
        if (is_rotate(st.opcode))
        begin
          next_st.neg  = st.result[7];
          next_st.zero = (st.result == 8'h00);
          if (st.opcode[byte_ops_pkg::OP_DEST_BIT])
            mem_we = 1'b1;
          else
            next_st.wreg = st.result;
        end
        else
        begin
          // fill writes the file, flags left alone
          mem_we = 1'b1;
        end
      end
      default: next_st.phase = byte_ops_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st        <= '0;
      st.phase  <= byte_ops_pkg::PH_IDLE;
      st.wreg   <= byte_ops_pkg::RST_WREG;
      st.opcode <= byte_ops_pkg::RST_OPCODE;
    end
    else
      st <= next_st;
  end

  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      file_mem[mem_waddr] <= mem_wdata;
  end

  // checks
  property p_rot_value;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q3 && is_rotate(st.opcode))
      |=> (st.result == {$past(st.operand[0]), $past(st.operand[7:1])});
  endproperty
  a_rot_value: assert property (p_rot_value) else $error("rotate result wrong");

  property p_rot_flags;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q4 && is_rotate(st.opcode))
      |=> (st.neg == $past(st.result[7])) && (st.zero == ($past(st.result) == 8'h00));
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate flags wrong");

  property p_dest_w;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q4 && is_rotate(st.opcode) && !st.opcode[9])
      |=> (st.wreg == $past(st.result));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("accumulator not written");

  property p_dest_f;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q4 && is_rotate(st.opcode) && st.opcode[9])
      |=> $stable(st.wreg) && (file_mem[$past(st.eff_addr)] == $past(st.result));
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("file write-back wrong");

  property p_bank_ptr;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q1 && st.opcode[8])
      |=> (st.eff_addr == {st.bank, st.opcode[7:0]});
  endproperty
  a_bank_ptr: assert property (p_bank_ptr) else $error("bank pointer not used");

  property p_access_bank;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q1 && !st.opcode[8]
      && !(st.ext_en && st.opcode[7:0] <= 8'h5F))
      |=> (st.eff_addr[AW-1:8] == {BANK_W{st.opcode[7:0] > 8'h5F}});
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

  property p_indexed;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q1 && !st.opcode[8] && st.ext_en
      && st.opcode[7:0] <= 8'h5F)
      |=> (st.eff_addr == AW'($past(st.index) + AW'($past(st.opcode[7:0]))));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_fill;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q4 && is_fill(st.opcode))
      |=> (file_mem[$past(st.eff_addr)] == 8'hFF) && $stable({st.neg, st.zero});
  endproperty
  a_fill: assert property (p_fill) else $error("fill result or flags wrong");

  property p_cycle;
    @(posedge clk_sys) disable iff (!resetn)
    (st.phase == byte_ops_pkg::PH_Q1)
      |=> (st.phase == byte_ops_pkg::PH_Q2) ##1 (st.phase == byte_ops_pkg::PH_Q3)
      ##1 (st.phase == byte_ops_pkg::PH_Q4) ##1 (st.phase == byte_ops_pkg::PH_IDLE);
  endproperty
  a_cycle: assert property (p_cycle) else $error("phase sequence broken");

  property p_cov_rot_w;
    @(posedge clk_sys) disable iff (!resetn)
    st.phase == byte_ops_pkg::PH_Q4 && is_rotate(st.opcode) && !st.opcode[9];
  endproperty
  c_rot_w: cover property (p_cov_rot_w);

  property p_cov_indexed_fill;
    @(posedge clk_sys) disable iff (!resetn)
    st.phase == byte_ops_pkg::PH_Q1 && is_fill(st.opcode) && st.ext_en && !st.opcode[8];
  endproperty
  c_indexed_fill: cover property (p_cov_indexed_fill);

  property p_cov_stall;
    @(posedge clk_sys) disable iff (!resetn)
    psel && st.phase != byte_ops_pkg::PH_IDLE;
  endproperty
  c_stall: cover property (p_cov_stall);

endmodule

`default_nettype wire

// ### sim/rotate_right_and_set_byte_ops_bench.sv
// self-checking apb bench for the rotate and fill datapath
`timescale 1ns/1ps
`default_nettype none

module rotate_right_and_set_byte_ops_bench;
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          check_count;

  byte_ops_core byte_ops_core_i (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 50)
      bad_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  function automatic logic [11:0] eff(input logic [15:0] op, input logic ext,
                                      input logic [3:0] bnk, input logic [11:0] idx);
    logic low;
    low = op[7:0] <= byte_ops_pkg::INDEXED_LIMIT;
    if (!op[8] && ext && low)
      return idx + {4'h0, op[7:0]};
    if (!op[8])
      return {low ? 4'h0 : 4'hF, op[7:0]};
    return {bnk, op[7:0]};
  endfunction

  task automatic run_op(input logic fill, input logic ext, input int i);
    logic [15:0] op;
    logic [7:0]  v;
    logic [7:0]  w0;
    logic [7:0]  res;
    logic [3:0]  bnk;
    logic [11:0] idx;
    logic [1:0]  fl;
    op  = $urandom;
    v   = $urandom;
    w0  = $urandom;
    bnk = $urandom;
    idx = $urandom;
    fl  = $urandom;
    if (i % 4 == 0)
      op[7:0] = 8'h5F + 8'(i % 8 / 4);
    if (i % 8 == 2)
      v = 8'h00;
    if (fill)
      op[15:9] = byte_ops_pkg::OPC_FILL;
    else
      op[15:10] = byte_ops_pkg::OPC_ROTATE;
    res = fill ? byte_ops_pkg::FILL_VALUE : {v[0], v[7:1]};
    apb(1'b1, byte_ops_pkg::OFF_CTRL, {31'h0, ext});
    apb(1'b1, byte_ops_pkg::OFF_BANK, {28'h0, bnk});
    apb(1'b1, byte_ops_pkg::OFF_INDEX, {20'h0, idx});
    apb(1'b1, byte_ops_pkg::OFF_WREG, {24'h0, w0});
    apb(1'b1, byte_ops_pkg::OFF_STATUS, {30'h0, fl});
    apb(1'b1, byte_ops_pkg::OFF_FILE_ADDR, {20'h0, eff(op, ext, bnk, idx)});
    apb(1'b1, byte_ops_pkg::OFF_FILE_DATA, {24'h0, v});
    apb(1'b1, byte_ops_pkg::OFF_INSTR, {16'h0, op});
    apb(1'b0, byte_ops_pkg::OFF_FILE_DATA, 32'h0);
    check("file", rd, {24'h0, (fill || op[9]) ? res : v});
    check("err", {31'h0, er}, 32'h0);
    apb(1'b0, byte_ops_pkg::OFF_WREG, 32'h0);
    check("wreg", rd, {24'h0, (!fill && !op[9]) ? res : w0});
    apb(1'b0, byte_ops_pkg::OFF_STATUS, 32'h0);
    check("flags", rd, {30'h0, fill ? fl : {res == 8'h00, res[7]}});
  endtask

  initial
  begin
    #(10 * 20000);
    bad_count++;
    finish_test();
  end

  initial
  begin
    resetn      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    bad_count   = 0;
    check_count = 0;
    void'($urandom(32'h3728F236));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 28; a += 4)
      if (a != 4)
      begin
        apb(1'b0, 8'(a), 32'h0);
        check("reset", rd, 32'h0);
      end
    // unmapped offsets are refused with an error and no data
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    check("unmapped wr", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    check("unmapped rd", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, byte_ops_pkg::OFF_INSTR, 32'h0);
    apb(1'b0, byte_ops_pkg::OFF_STATUS, 32'h0);
    check("unknown op", rd, 32'h8);
    for (int i = 0; i < 80; i++)
      run_op(i[0], i[1], i);
    finish_test();
  end
endmodule

`default_nettype wire
